// *** hw/aicp_ctrl.sv ***
// converter control: input routing, clock divider, amplifier and reference
// selection, start sequencing, busy flag and result registers
// assumes the analog core shares I_CLK_SYS and holds I_RESULT valid on the last tick of O_CONVERT
//
// Our own choices: the address map and the strobed register port.

module aicp_ctrl #(
  parameter int SAMPLE_TICKS  = aicp_pkg::SAMPLE_TICKS,
  parameter int CONVERT_TICKS = aicp_pkg::CONVERT_TICKS
) (
  input  wire logic                      I_CLK_SYS,
  input  wire logic                      I_RSTN,
  input  wire logic [2:0]                I_ADDR,
  input  wire logic [7:0]                I_WDATA,
  input  wire logic                      I_WR,
  input  wire logic                      I_RD,
  output logic      [7:0]                O_RDATA,
  input  wire logic [aicp_pkg::RESULT_W-1:0] I_RESULT,
  output aicp_pkg::aicp_route_t          O_ROUTE,
  output logic                           O_CONV_CLK_EN,
  output logic                           O_ADC_POWER,
  output logic                           O_SAMPLE,
  output logic                           O_CONVERT,
  output logic                           O_BUSY,
  output logic                           O_DONE
);

  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] SAMPLE_LAST  = CNT_W'(SAMPLE_TICKS - 1);
  localparam logic [CNT_W-1:0] CONVERT_LAST = CNT_W'(CONVERT_TICKS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO     = '0;
  localparam logic [aicp_pkg::DIV_W-1:0] DIV_ONE = 7'h01;

  generate
    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 2**CNT_W || CONVERT_TICKS < 1 || CONVERT_TICKS > 2**CNT_W) begin : g_bad
      $error("aicp_ctrl: tick counts must lie between 1 and 16");
    end
  endgenerate

  // mask of divider bits that must all be one for a tick at the chosen ratio
  function automatic logic [aicp_pkg::DIV_W-1:0] div_mask(input logic [2:0] sel);
    div_mask = aicp_pkg::DIV_W'((DIV_ONE << sel) - DIV_ONE);
  endfunction

  // input-select decode shared by routing and the external-path switch
  function automatic aicp_pkg::aicp_insrc_t src_decode(input logic [3:0] code);
    case (code)
      4'b0001: src_decode = aicp_pkg::AICP_SRC_SUPPLY;
      4'b0010: src_decode = aicp_pkg::AICP_SRC_SUPPLY_HALF;
      4'b0011: src_decode = aicp_pkg::AICP_SRC_SUPPLY_QTR;
      4'b0101: src_decode = aicp_pkg::AICP_SRC_AMP;
      4'b0110: src_decode = aicp_pkg::AICP_SRC_AMP_HALF;
      4'b0111: src_decode = aicp_pkg::AICP_SRC_AMP_QTR;
      4'b1000: src_decode = aicp_pkg::AICP_SRC_SENSE_A;
      4'b1001: src_decode = aicp_pkg::AICP_SRC_SENSE_B;
      aicp_pkg::SRC_CODE_GND_A,
      aicp_pkg::SRC_CODE_GND_B: src_decode = aicp_pkg::AICP_SRC_GROUND;
      default: src_decode = aicp_pkg::AICP_SRC_EXT;
    endcase
  endfunction

  // control registers
  logic        start_q;
  logic        power_q;
  logic        justify_q;
  logic [3:0]  ext_chan_q;
  logic [3:0]  src_code_q;
  logic [2:0]  div_sel_q;
  logic        amp_en_q;
  logic        amp_insel_q;
  logic [1:0]  ref_code_q;
  logic [1:0]  gain_code_q;
  logic [aicp_pkg::RESULT_W-1:0] result_q;

  // sequencing state
  aicp_pkg::aicp_state_t         state_q;
  aicp_pkg::aicp_state_t         state_d;
  logic [CNT_W-1:0]              tick_cnt_q;
  logic [CNT_W-1:0]              tick_cnt_d;
  logic [aicp_pkg::DIV_W-1:0]    div_cnt_q;
  logic [aicp_pkg::DIV_W-1:0]    div_mask_w;
  logic                          tick_q;
  logic                          tick_d;
  logic                          busy_q;
  logic                          busy_d;
  logic                          done_q;
  logic                          done_d;
  logic                          sample_q;
  logic                          convert_q;
  logic [7:0]                    rdata_q;
  logic [7:0]                    rdata_d;
  aicp_pkg::aicp_route_t         route_q;
  aicp_pkg::aicp_route_t         route_d;

  // write decode
  wire wr_main   = I_WR && (I_ADDR == aicp_pkg::ADDR_MAIN_CTRL);
  wire wr_inclk  = I_WR && (I_ADDR == aicp_pkg::ADDR_INPUT_CLOCK);
  wire wr_ampref = I_WR && (I_ADDR == aicp_pkg::ADDR_AMP_REF);

  // high-then-low on the start bit; a level never starts anything
  wire start_fall  = wr_main && start_q && !I_WDATA[aicp_pkg::MAIN_START_BIT];
  // refused while unpowered or already converting
  wire start_go    = start_fall && power_q && !busy_q;
  wire last_tick   = tick_q && (state_q == aicp_pkg::AICP_ST_CONVERT) && (tick_cnt_q == CONVERT_LAST);

  // divider tap follows the select field from the next edge on
  assign div_mask_w = div_mask(div_sel_q);
  assign tick_d     = ((div_cnt_q & div_mask_w) == div_mask_w);

  // sequencer: idle until a start, sample for SAMPLE_TICKS ticks, then convert
  always_comb begin
    state_d    = state_q;
    tick_cnt_d = tick_cnt_q;
    busy_d     = busy_q;
    done_d     = 1'b0;
    case (state_q)
      aicp_pkg::AICP_ST_IDLE: begin
        if (start_go) begin
          state_d    = aicp_pkg::AICP_ST_SAMPLE;
          tick_cnt_d = CNT_ZERO;
          busy_d     = 1'b1;
        end
      end
      aicp_pkg::AICP_ST_SAMPLE: begin
        if (tick_q) begin
          if (tick_cnt_q == SAMPLE_LAST) begin
            state_d    = aicp_pkg::AICP_ST_CONVERT;
            tick_cnt_d = CNT_ZERO;
          end else begin
            tick_cnt_d = tick_cnt_q + 1'b1;
          end
        end
      end
      aicp_pkg::AICP_ST_CONVERT: begin
        if (last_tick) begin
          state_d = aicp_pkg::AICP_ST_IDLE;
          busy_d  = 1'b0;
          done_d  = 1'b1;
        end else if (tick_q) begin
          tick_cnt_d = tick_cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = aicp_pkg::AICP_ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
    // powering down aborts a conversion without a completion
    if (!power_q) begin
      state_d    = aicp_pkg::AICP_ST_IDLE;
      tick_cnt_d = CNT_ZERO;
      busy_d     = 1'b0;
      done_d     = 1'b0;
    end
  end

  // analog routing
  wire aicp_pkg::aicp_insrc_t src_w = src_decode(src_code_q);
  wire aicp_pkg::aicp_ref_t   ref_w = ref_code_q[1] ? aicp_pkg::AICP_REF_AMP : aicp_pkg::aicp_ref_t'(ref_code_q);

  always_comb begin
    route_d                  = route_q;
    route_d.int_source       = src_w;
    route_d.ext_chan_connect = (src_w == aicp_pkg::AICP_SRC_EXT);
    route_d.ext_chan         = ext_chan_q;
    route_d.ref_source       = ref_w;
    route_d.ref_pin_connect  = (ref_w == aicp_pkg::AICP_REF_PIN);
    route_d.amp_enable       = amp_en_q;
    route_d.amp_pin_connect  = !amp_insel_q;
    route_d.bandgap_connect  = amp_insel_q;
    route_d.amp_gain         = {1'b0, gain_code_q} + 3'h1;
  end

  // result layout for reads
  wire [7:0] res_lo_w = justify_q ? result_q[7:0] : {result_q[3:0], 4'h0};
  wire [7:0] res_hi_w = justify_q ? {4'h0, result_q[11:8]} : result_q[11:4];

  wire [7:0] main_rd_w  = {start_q, busy_q, power_q, justify_q, ext_chan_q};
  wire [7:0] inclk_rd_w = {src_code_q, 1'b0, div_sel_q};
  wire [7:0] ampref_rd_w = {amp_en_q, 2'b00, amp_insel_q, ref_code_q, gain_code_q};

  always_comb begin
    case (I_ADDR)
      aicp_pkg::ADDR_MAIN_CTRL:   rdata_d = main_rd_w;
      aicp_pkg::ADDR_INPUT_CLOCK: rdata_d = inclk_rd_w;
      aicp_pkg::ADDR_AMP_REF:     rdata_d = ampref_rd_w;
      aicp_pkg::ADDR_RESULT_LO:   rdata_d = res_lo_w;
      aicp_pkg::ADDR_RESULT_HI:   rdata_d = res_hi_w;
      default:                    rdata_d = 8'h00;
    endcase
    // read data stand only in the cycle after the strobe
    if (!I_RD) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      start_q   <= 1'b0;
      power_q   <= 1'b0;
      justify_q <= 1'b0;
      ext_chan_q <= 4'h0;
    end else if (wr_main) begin
      start_q    <= I_WDATA[aicp_pkg::MAIN_START_BIT];
      power_q    <= I_WDATA[aicp_pkg::MAIN_POWER_BIT];
      justify_q  <= I_WDATA[aicp_pkg::MAIN_JUSTIFY_BIT];
      ext_chan_q <= I_WDATA[aicp_pkg::MAIN_CHAN_LSB +: 4];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      src_code_q <= 4'h0;
      div_sel_q  <= 3'h0;
    end else if (wr_inclk) begin
      src_code_q <= I_WDATA[aicp_pkg::INCLK_SRC_LSB +: 4];
      div_sel_q  <= I_WDATA[aicp_pkg::INCLK_DIV_LSB +: 3];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      amp_en_q    <= 1'b0;
      amp_insel_q <= 1'b0;
      ref_code_q  <= 2'h0;
      gain_code_q <= 2'h0;
    end else if (wr_ampref) begin
      amp_en_q    <= I_WDATA[aicp_pkg::AMPREF_EN_BIT];
      amp_insel_q <= I_WDATA[aicp_pkg::AMPREF_INSEL_BIT];
      ref_code_q  <= I_WDATA[aicp_pkg::AMPREF_REF_LSB +: 2];
      gain_code_q <= I_WDATA[aicp_pkg::AMPREF_GAIN_LSB +: 2];
    end
  end

  // result only moves on a completed, powered conversion
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      result_q <= '0;
    end else if (last_tick && power_q) begin
      result_q <= I_RESULT;
    end
  end

  // free-running divider; never reset by a start so the tap phase is stable
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + DIV_ONE;
      tick_q    <= tick_d;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q    <= aicp_pkg::AICP_ST_IDLE;
      tick_cnt_q <= CNT_ZERO;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      sample_q   <= 1'b0;
      convert_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      tick_cnt_q <= tick_cnt_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
      // phase outputs get their own flops so no decode sits after the state register
      sample_q   <= (state_d == aicp_pkg::AICP_ST_SAMPLE);
      convert_q  <= (state_d == aicp_pkg::AICP_ST_CONVERT);
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_q <= 8'h00;
      route_q <= '{ext_chan_connect: 1'b1, ext_chan: 4'h0, int_source: aicp_pkg::AICP_SRC_EXT,
                   ref_source: aicp_pkg::AICP_REF_SUPPLY, ref_pin_connect: 1'b0, amp_enable: 1'b0,
                   amp_pin_connect: 1'b1, bandgap_connect: 1'b0, amp_gain: 3'h1};
    end else begin
      rdata_q <= rdata_d;
      route_q <= route_d;
    end
  end

  assign O_RDATA       = rdata_q;
  assign O_ROUTE       = route_q;
  assign O_CONV_CLK_EN = tick_q;
  assign O_ADC_POWER   = power_q;
  assign O_BUSY        = busy_q;
  assign O_DONE        = done_q;
  assign O_SAMPLE      = sample_q;
  assign O_CONVERT     = convert_q;

endmodule

// *** hw/aicp_pkg.sv ***
// package for the converter input, clock and amplifier control block
// assumes an 8-bit register port on the system clock and an analog core beside it
package aicp_pkg;

  // register map, word addresses on the 3-bit port
  localparam logic [2:0] ADDR_MAIN_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_INPUT_CLOCK = 3'h1;
  localparam logic [2:0] ADDR_AMP_REF     = 3'h2;
  localparam logic [2:0] ADDR_RESULT_LO   = 3'h3;
  localparam logic [2:0] ADDR_RESULT_HI   = 3'h4;

  // converter_main_control fields
  localparam int MAIN_START_BIT   = 7;
  localparam int MAIN_BUSY_BIT    = 6;
  localparam int MAIN_POWER_BIT   = 5;
  localparam int MAIN_JUSTIFY_BIT = 4;
  localparam int MAIN_CHAN_LSB    = 0;

  // input_and_clock_select fields
  localparam int INCLK_SRC_LSB = 4;
  localparam int INCLK_DIV_LSB = 0;

  // amplifier_and_reference_control fields
  localparam int AMPREF_EN_BIT     = 7;
  localparam int AMPREF_INSEL_BIT  = 4;
  localparam int AMPREF_REF_LSB    = 2;
  localparam int AMPREF_GAIN_LSB   = 0;

  localparam logic [7:0] REG_RESET = 8'h00;

  // conversion timing in converter clock ticks, then result and divider widths in bits
  localparam int SAMPLE_TICKS  = 4;
  localparam int CONVERT_TICKS = 12;
  localparam int RESULT_W      = 12;
  localparam int DIV_W         = 7;

  // input-select codes that need decoding
  localparam logic [3:0] SRC_CODE_GND_A = 4'h0a;
  localparam logic [3:0] SRC_CODE_GND_B = 4'h0b;

  typedef enum logic [3:0] {
    AICP_SRC_EXT         = 4'b0000,
    AICP_SRC_SUPPLY      = 4'b0001,
    AICP_SRC_SUPPLY_HALF = 4'b0010,
    AICP_SRC_SUPPLY_QTR  = 4'b0011,
    AICP_SRC_AMP         = 4'b0100,
    AICP_SRC_AMP_HALF    = 4'b0101,
    AICP_SRC_AMP_QTR     = 4'b0110,
    AICP_SRC_SENSE_A     = 4'b0111,
    AICP_SRC_SENSE_B     = 4'b1000,
    AICP_SRC_GROUND      = 4'b1001
  } aicp_insrc_t;

  typedef enum logic [1:0] {
    AICP_REF_SUPPLY = 2'b00,
    AICP_REF_PIN    = 2'b01,
    AICP_REF_AMP    = 2'b10
  } aicp_ref_t;

  typedef enum logic [1:0] {
    AICP_ST_IDLE    = 2'b00,
    AICP_ST_SAMPLE  = 2'b01,
    AICP_ST_CONVERT = 2'b10
  } aicp_state_t;

  // routing controls toward the analog multiplexer, reference and amplifier
  typedef struct packed {
    logic        ext_chan_connect;
    logic [3:0]  ext_chan;
    aicp_insrc_t int_source;
    aicp_ref_t   ref_source;
    logic        ref_pin_connect;
    logic        amp_enable;
    logic        amp_pin_connect;
    logic        bandgap_connect;
    logic [2:0]  amp_gain;
  } aicp_route_t;

endpackage

// *** test/aicp_ctrl_asserts.sv ***
// checker for the converter control block
// assumes it is bound to aicp_ctrl and sees that module's ports only
module aicp_ctrl_asserts #(
  parameter int SAMPLE_TICKS  = aicp_pkg::SAMPLE_TICKS,
  parameter int CONVERT_TICKS = aicp_pkg::CONVERT_TICKS
) (
  input wire logic                 I_CLK_SYS,
  input wire logic                 I_RSTN,
  input wire logic [2:0]           I_ADDR,
  input wire logic [7:0]           I_WDATA,
  input wire logic                 I_WR,
  input wire logic                 I_RD,
  input wire logic [7:0]           O_RDATA,
  input wire aicp_pkg::aicp_route_t O_ROUTE,
  input wire logic                 O_CONV_CLK_EN,
  input wire logic                 O_ADC_POWER,
  input wire logic                 O_SAMPLE,
  input wire logic                 O_CONVERT,
  input wire logic                 O_BUSY,
  input wire logic                 O_DONE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);

  logic       start_q;
  logic [4:0] smp_q;
  logic [4:0] cnv_q;
  wire        wr_main = I_WR && I_ADDR == aicp_pkg::ADDR_MAIN_CTRL;
  wire        wr_ic   = I_WR && I_ADDR == aicp_pkg::ADDR_INPUT_CLOCK;
  wire        wr_ar   = I_WR && I_ADDR == aicp_pkg::ADDR_AMP_REF;

  function automatic logic ext_src(input logic [3:0] c);
    return c == 4'h0 || c == 4'h4 || c[3:2] == 2'b11;
  endfunction

  // ticks seen per phase; cleared while the phase is low
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      start_q <= 1'b0;
      smp_q   <= 5'h00;
      cnv_q   <= 5'h00;
    end else begin
      if (wr_main) start_q <= I_WDATA[7];
      smp_q <= O_SAMPLE ? smp_q + 5'(O_CONV_CLK_EN) : 5'h00;
      cnv_q <= O_CONVERT ? cnv_q + 5'(O_CONV_CLK_EN) : 5'h00;
    end
  end

  sequence s_start;
    wr_main && !I_WDATA[7] && start_q && O_ADC_POWER && !O_BUSY;
  endsequence
  sequence s_finish;
    (!O_BUSY && $past(O_CONVERT)) ##1 !O_DONE;
  endsequence

  property p_ic_unused; I_RD && I_ADDR == aicp_pkg::ADDR_INPUT_CLOCK |=> !O_RDATA[3]; endproperty
  property p_ar_unused; I_RD && I_ADDR == aicp_pkg::ADDR_AMP_REF |=> O_RDATA[6:5] == 2'b00; endproperty
  // routing lags a write by two edges: control register, then routing flop
  property p_ext_path; wr_ic |-> ##2 O_ROUTE.ext_chan_connect == ext_src($past(I_WDATA[7:4], 2)); endproperty
  property p_gain; wr_ar |-> ##2 O_ROUTE.amp_gain == {1'b0, $past(I_WDATA[1:0], 2)} + 3'h1; endproperty
  property p_ref; wr_ar |-> ##2 O_ROUTE.ref_pin_connect == ($past(I_WDATA[3:2], 2) == 2'b01); endproperty
  property p_amp;
    wr_ar |-> ##2 O_ROUTE.amp_enable == $past(I_WDATA[7], 2) && O_ROUTE.bandgap_connect == $past(I_WDATA[4], 2)
      && O_ROUTE.amp_pin_connect == !$past(I_WDATA[4], 2);
  endproperty
  property p_start; s_start |=> O_BUSY && O_SAMPLE; endproperty
  property p_level; wr_main && I_WDATA[7] && !O_BUSY |=> !O_BUSY; endproperty
  property p_sample; $rose(O_CONVERT) |-> smp_q == SAMPLE_TICKS; endproperty
  property p_convert; $fell(O_CONVERT) |-> O_DONE == (cnv_q == CONVERT_TICKS); endproperty
  property p_finish; O_DONE |-> s_finish; endproperty
  property p_abort; $fell(O_ADC_POWER) |-> ##[0:1] !O_BUSY; endproperty

  a_ic_unused: assert property (p_ic_unused) else $error("unused input/clock bit read high");
  a_ar_unused: assert property (p_ar_unused) else $error("unused amplifier bits read high");
  a_ext_path: assert property (p_ext_path) else $error("external path connect wrong");
  a_gain: assert property (p_gain) else $error("amplifier gain wrong");
  a_ref: assert property (p_ref) else $error("reference pin connect wrong");
  a_amp: assert property (p_amp) else $error("amplifier enable or input wrong");
  a_start: assert property (p_start) else $error("start sequence did not set busy");
  a_level: assert property (p_level) else $error("start level began a conversion");
  a_sample: assert property (p_sample) else $error("sampling tick count wrong");
  a_convert: assert property (p_convert) else $error("conversion tick count wrong");
  a_finish: assert property (p_finish) else $error("completion pulse wrong");
  a_abort: assert property (p_abort) else $error("busy held after power off");
endmodule

bind aicp_ctrl aicp_ctrl_asserts #(.SAMPLE_TICKS(SAMPLE_TICKS), .CONVERT_TICKS(CONVERT_TICKS)) u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .O_RDATA(O_RDATA), .O_ROUTE(O_ROUTE), .O_CONV_CLK_EN(O_CONV_CLK_EN), .O_ADC_POWER(O_ADC_POWER),
  .O_SAMPLE(O_SAMPLE), .O_CONVERT(O_CONVERT), .O_BUSY(O_BUSY), .O_DONE(O_DONE)
);

// *** test/aicp_core_model.sv ***
// behavioural analog core driving the result bus
// assumes the control block samples the bus inside its convert phase
module aicp_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_convert,
  input  wire logic [11:0] i_value,
  output logic      [11:0] o_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cyc_q = 12'h000;
  always @(posedge i_clk) cyc_q <= cyc_q + 12'h001;
  // valid only while converting; a changing pattern exposes a stale capture
  assign o_result = i_convert ? i_value : ~i_value ^ cyc_q;
endmodule

// *** test/aicp_ctrl_tb.sv ***
// self-checking bench for the converter control block
// assumes aicp_ctrl, its checker and the core model are compiled before it
module aicp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk   = 1'b0;
  logic                  rstn  = 1'b0;
  logic [2:0]            addr  = 3'h0;
  logic [7:0]            wdata = 8'h00;
  logic                  wr    = 1'b0;
  logic                  rd    = 1'b0;
  logic [11:0]           value = 12'h000;
  logic [7:0]            rdata;
  logic [11:0]           result;
  aicp_pkg::aicp_route_t route;
  logic                  clk_en, pwr, smp, cnv, busy, done;
  int                    err_count = 0;
  int                    num_checks = 0;
  int                    seed = 32'h0000_9b7b;
  int                    reg_m[8];
  int                    mask[8] = '{8'hbf, 8'hf7, 8'h9f, 0, 0, 0, 0, 0};
  int                    r, nb, nd, nt, ns, d2, res_m;
  // routed source expected for each input-select code
  aicp_pkg::aicp_insrc_t src_m[16] = '{aicp_pkg::AICP_SRC_EXT, aicp_pkg::AICP_SRC_SUPPLY,
    aicp_pkg::AICP_SRC_SUPPLY_HALF, aicp_pkg::AICP_SRC_SUPPLY_QTR, aicp_pkg::AICP_SRC_EXT, aicp_pkg::AICP_SRC_AMP,
    aicp_pkg::AICP_SRC_AMP_HALF, aicp_pkg::AICP_SRC_AMP_QTR, aicp_pkg::AICP_SRC_SENSE_A, aicp_pkg::AICP_SRC_SENSE_B,
    aicp_pkg::AICP_SRC_GROUND, aicp_pkg::AICP_SRC_GROUND, aicp_pkg::AICP_SRC_EXT, aicp_pkg::AICP_SRC_EXT,
    aicp_pkg::AICP_SRC_EXT, aicp_pkg::AICP_SRC_EXT};

  aicp_ctrl i_dut (
    .I_CLK_SYS(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_RESULT(result), .O_ROUTE(route), .O_CONV_CLK_EN(clk_en), .O_ADC_POWER(pwr),
    .O_SAMPLE(smp), .O_CONVERT(cnv), .O_BUSY(busy), .O_DONE(done)
  );
  aicp_core_model u_core (.i_clk(clk), .i_convert(cnv), .i_value(value), .o_result(result));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    reg_m[a] = d & mask[a];
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // cycles to the next converter tick; a lost tick ends the run
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (clk_en !== 1'b1 && n < 300);
    if (n >= 300) begin
      err_count++;
      conclude();
    end
  endtask

  task automatic watch(input int len);
    nb = 0;
    nd = 0;
    nt = 0;
    ns = 0;
    repeat (len) begin
      #1 nb += busy;
      nd += done;
      nt += busy && clk_en;
      ns += smp && clk_en;
      @(posedge clk);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) rd_chk(a[2:0], 8'h00);
    chk(route.ext_chan_connect, 1'b1);
    chk(route.amp_gain, 3'h1);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      d2 = r[15:8];
      wr_reg(3'h1, {i[3:0], r[3:0]});
      wr_reg(3'h2, d2[7:0]);
      wr_reg(3'h0, r[23:16] & 8'h5f);
      wr_reg(3'h5, r[31:24]);
      wr_reg(3'h3, r[31:24]);
      rd_chk(3'h1, 8'(reg_m[1]));
      rd_chk(3'h2, 8'(reg_m[2]));
      rd_chk(3'h0, 8'(reg_m[0]));
      rd_chk(3'h3, 8'h00);
      chk(route.ext_chan_connect, i inside {0, 4, [12:15]});
      if (i inside {0, 4, [12:15]}) chk(route.ext_chan, reg_m[0] & 15);
      if (i inside {10, 11}) chk(route.int_source, aicp_pkg::AICP_SRC_GROUND);
      chk(route.int_source, src_m[i]);
      chk(route.amp_gain, d2[1:0] + 1);
      chk(route.ref_source, d2[3] ? 2 : d2[2]);
      chk(route.ref_pin_connect, d2[3:2] == 1);
      chk({route.amp_enable, route.bandgap_connect, route.amp_pin_connect}, {d2[7], d2[4], !d2[4]});
    end
    $display("test routing and registers done");
    for (int dv = 0; dv < 8; dv++) begin
      wr_reg(3'h1, dv[7:0]);
      gap(nb);
      gap(nb);
      gap(nb);
      chk(nb, 1 << dv);
    end
    $display("test clock divider done");
    for (int j = 0; j < 3; j++) begin
      r = $random(seed);
      res_m = r[11:0];
      value <= r[11:0];
      // last pass uses the only ratio whose converter period is in range at this clock
      wr_reg(3'h1, (j == 2) ? 8'h07 : 8'h00);
      wr_reg(3'h0, 8'h20);
      wr_reg(3'h0, 8'ha0);
      repeat (5) @(posedge clk);
      #1 chk({busy, pwr}, 2'b01);
      wr_reg(3'h0, {3'b001, j[0], 4'h0});
      watch((j == 2) ? 2200 : 40);
      if (j < 2) chk(nb, 16);
      chk(nt, aicp_pkg::SAMPLE_TICKS + aicp_pkg::CONVERT_TICKS);
      chk(ns, aicp_pkg::SAMPLE_TICKS);
      chk(nd, 1);
      rd_chk(3'h0, {3'b001, j[0], 4'h0});
      rd_chk(3'h4, 8'(j[0] ? res_m >> 8 : res_m >> 4));
      rd_chk(3'h3, 8'(j[0] ? res_m : res_m << 4));
    end
    wr_reg(3'h1, 8'h00);
    $display("test conversion done");
    wr_reg(3'h0, 8'h80);
    wr_reg(3'h0, 8'h00);
    watch(20);
    chk(nb + nd, 0);
    value <= ~value;
    wr_reg(3'h0, 8'h20);
    wr_reg(3'h0, 8'ha0);
    wr_reg(3'h0, 8'h20);
    repeat (6) @(posedge clk);
    wr_reg(3'h0, 8'h00);
    watch(30);
    chk(nd, 0);
    chk(busy, 1'b0);
    chk(pwr, 1'b0);
    rd_chk(3'h4, 8'(res_m >> 4));
    $display("test refusal and abort done");
    conclude();
  end
endmodule
